//--- core/pmc_pkg.sv
// constants, types and field layout for prescaler and power mode control
package pmc_pkg;

  localparam int SYS_W = 13;
  localparam int SUB_W = 5;
  localparam int QUART_W = 2;
  localparam int DIV_W = 7;

  // register addresses
  localparam logic [15:0] ADDR_SCR1 = 16'hfff0;
  localparam logic [15:0] ADDR_SCR2 = 16'hfff1;
  localparam logic [15:0] ADDR_TMA = 16'hffa6;
  localparam logic [15:0] ADDR_STAT = 16'hffa7;

  // reset values
  localparam logic [7:0] SCR1_RST = 8'h07;
  localparam logic [7:0] SCR2_RST = 8'he0;
  localparam logic [3:0] TMA_RST = 4'h0;

  // writable bits and bits that always read as one
  localparam logic [7:0] SCR1_WMASK = 8'hfb;
  localparam logic [7:0] SCR1_ONES = 8'h04;
  localparam logic [7:0] SCR2_WMASK = 8'h0c;
  localparam logic [7:0] SCR2_ONES = 8'he0;

  // field positions
  localparam int SCR1_SOFTWARE_STANDBY = 7;
  localparam int SCR1_LOW_SPEED_ON = 3;
  localparam int SCR1_MA_LO = 0;
  localparam int SCR2_DIRECT_TRANSFER_ON = 3;
  localparam int SCR2_MEDIUM_SPEED_ON = 2;
  localparam int TMA_SEL_HI = 3;
  localparam int TMA_SEL_MID = 2;

  // medium speed: divisor of the prescaler input is this times 2**field, smallest at field zero
  localparam logic [DIV_W-1:0] MED_DIV_MIN = 7'h08;
  // last subclock rising-edge count before a subclock prescaler step
  localparam logic [QUART_W-1:0] QUART_LAST = 2'h3;

  typedef enum logic [2:0] {
    MODE_ACT_HI,
    MODE_ACT_MED,
    MODE_SUBACT,
    MODE_SLP_HI,
    MODE_SLP_MED,
    MODE_SUBSLP,
    MODE_WATCH,
    MODE_STBY
  } pmc_mode_e;

  // what is kept running in the current mode
  typedef struct packed {
    logic sys_osc;
    logic cpu;
    logic periph;
    logic pwm;
    logic timer_a;
  } pmc_run_s;

endpackage

//--- core/pmc_counter.sv
// small up-counter with synchronous clear, used for prescalers and dividers
`timescale 1ns/1ps
module pmc_counter #(
  parameter int W = 13
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // control
  input wire logic clr,
  input wire logic inc,
  // count
  output logic [W-1:0] q
);

  // clear beats increment so a stop never leaves a stale count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else if (ce) begin
      if (clr) begin
        q <= '0;
      end else if (inc) begin
        q <= q + 1'b1;
      end
    end
  end

endmodule

//--- core/pmc_top.sv
// prescaler s, prescaler w, mode controller and control registers
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ps
module pmc_top
  import pmc_pkg::*;
#(
  parameter int SYS_BITS = SYS_W,
  parameter int SUB_BITS = SUB_W
) (
  // clock, reset, clock enable
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic CE,
  // register port
  input wire logic [15:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // cpu events
  input wire logic SLEEP_REQ,
  input wire logic WAKE,
  // subclock pin, asynchronous to CLK
  input wire logic SUB_CLK,
  // prescaler taps and mode state
  output logic [SYS_BITS-1:0] SYS_TAPS,
  output logic [SUB_BITS-1:0] SUB_TAPS,
  output pmc_mode_e MODE,
  output pmc_run_s RUN
);

  logic [7:0] scr1_q;
  logic [7:0] scr2_q;
  logic [3:0] tma_q;
  logic [7:0] rdata_q;
  pmc_mode_e mode_q;
  pmc_mode_e mode_d;
  pmc_run_s run_q;
  pmc_run_s run_d;
  logic sub_meta_q;
  logic sub_sync_q;
  logic sub_prev_q;
  logic [DIV_W-1:0] div_q;
  logic [SYS_BITS-1:0] sys_cnt;
  logic [SUB_BITS-1:0] sub_cnt;
  logic [QUART_W-1:0] quart_cnt;

  // register decode
  wire sel_scr1 = ADDR == ADDR_SCR1;
  wire sel_scr2 = ADDR == ADDR_SCR2;
  wire sel_tma = ADDR == ADDR_TMA;
  wire sel_stat = ADDR == ADDR_STAT;
  wire wr_scr1 = WR && sel_scr1;
  wire wr_scr2 = WR && sel_scr2;
  wire wr_tma = WR && sel_tma;
  // both timer A select bits written as one clear prescaler w
  wire tma_clr = wr_tma && WDATA[TMA_SEL_HI] && WDATA[TMA_SEL_MID];

  // control fields
  wire [1:0] ma = scr1_q[SCR1_MA_LO +: 2];
  wire software_standby = scr1_q[SCR1_SOFTWARE_STANDBY];
  wire low_speed_on = scr1_q[SCR1_LOW_SPEED_ON];
  wire medium_speed_on = scr2_q[SCR2_MEDIUM_SPEED_ON];
  wire direct_transfer_on = scr2_q[SCR2_DIRECT_TRANSFER_ON];
  wire tsel = tma_q[TMA_SEL_HI];

  // mode classes
  wire is_hi = (mode_q == MODE_ACT_HI) || (mode_q == MODE_SLP_HI);
  wire is_med = (mode_q == MODE_ACT_MED) || (mode_q == MODE_SLP_MED);
  wire sys_stop = !(is_hi || is_med);
  wire runs_code = (mode_q == MODE_ACT_HI) || (mode_q == MODE_ACT_MED) ||
                   (mode_q == MODE_SUBACT);

  // medium speed divider: terminal count is divisor minus one
  wire [DIV_W-1:0] div_last = DIV_W'((MED_DIV_MIN << ma) - 1'b1);
  wire med_tick = is_med && (div_q == div_last);
  // prescaler s steps every clock at high speed, per divider tick at medium
  wire sys_inc = is_hi || med_tick;

  // divider runs only in medium modes so a new ratio starts clean
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      div_q <= '0;
    end else if (CE) begin
      div_q <= (!is_med || med_tick) ? '0 : div_q + 1'b1;
    end
  end

  // prescaler s: cleared by reset and by every stop mode, unreachable from the bus
  pmc_counter #(.W(SYS_BITS)) u_sys_prescaler (
    .clk(CLK),
    .rst_n(RESET_N),
    .ce(CE),
    .clr(sys_stop),
    .inc(sys_inc),
    .q(sys_cnt)
  );

  // subclock pin synchroniser; only the second stage feeds the edge detector
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sub_meta_q <= 1'b0;
      sub_sync_q <= 1'b0;
      sub_prev_q <= 1'b0;
    end else if (CE) begin
      sub_meta_q <= SUB_CLK;
      sub_sync_q <= sub_meta_q;
      sub_prev_q <= sub_sync_q;
    end
  end

  wire sub_rise = sub_sync_q && !sub_prev_q;
  // quarter of the watch clock is the prescaler w input
  wire sub_step = sub_rise && (quart_cnt == QUART_LAST);

  pmc_counter #(.W(QUART_W)) u_sub_quarter (
    .clk(CLK),
    .rst_n(RESET_N),
    .ce(CE),
    .clr(1'b0),
    .inc(sub_rise),
    .q(quart_cnt)
  );

  // prescaler w ignores the mode: it counts while the subclock toggles
  pmc_counter #(.W(SUB_BITS)) u_sub_prescaler (
    .clk(CLK),
    .rst_n(RESET_N),
    .ce(CE),
    .clr(tma_clr),
    .inc(sub_step),
    .q(sub_cnt)
  );

  // sleep destination decode from the five control bits
  wire row_a = !low_speed_on && !medium_speed_on && !software_standby && !direct_transfer_on;
  wire row_b = !low_speed_on && medium_speed_on && !software_standby && !direct_transfer_on;
  wire row_c = low_speed_on && !software_standby && tsel && !direct_transfer_on;
  wire row_d = !low_speed_on && software_standby && !tsel && !direct_transfer_on;
  wire row_e = software_standby && tsel && !direct_transfer_on;
  wire row_f = !low_speed_on && !medium_speed_on && !software_standby && direct_transfer_on;
  wire row_g = !low_speed_on && medium_speed_on && !software_standby && direct_transfer_on;
  wire row_h = !low_speed_on && medium_speed_on && software_standby && tsel && direct_transfer_on;
  wire row_i = low_speed_on && software_standby && tsel && direct_transfer_on;
  wire row_j = !low_speed_on && !medium_speed_on && software_standby && tsel && direct_transfer_on;
  wire sleep_ok = row_a || row_b || row_c || row_d || row_e ||
                  row_f || row_g || row_h || row_i || row_j;
  wire pmc_mode_e sleep_dest =
    row_a ? MODE_SLP_HI :
    row_b ? MODE_SLP_MED :
    row_c ? MODE_SUBSLP :
    row_d ? MODE_STBY :
    row_e ? MODE_WATCH :
    row_f ? MODE_ACT_HI :
    row_g ? MODE_ACT_MED :
    row_h ? MODE_ACT_MED :
    row_i ? MODE_SUBACT :
    MODE_ACT_HI;

  // wake target from watch or standby follows the speed bits
  wire pmc_mode_e wake_act = medium_speed_on ? MODE_ACT_MED : MODE_ACT_HI;

  // mode sequencer: sleep only leaves running modes, wake only halted ones
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      MODE_ACT_HI, MODE_ACT_MED, MODE_SUBACT: begin
        if (SLEEP_REQ && sleep_ok) begin
          mode_d = sleep_dest;
        end
      end
      MODE_SLP_HI: begin
        if (WAKE) begin
          mode_d = MODE_ACT_HI;
        end
      end
      MODE_SLP_MED: begin
        if (WAKE) begin
          mode_d = MODE_ACT_MED;
        end
      end
      MODE_SUBSLP: begin
        if (WAKE) begin
          mode_d = MODE_SUBACT;
        end
      end
      MODE_WATCH: begin
        if (WAKE) begin
          mode_d = low_speed_on ? MODE_SUBACT : wake_act;
        end
      end
      MODE_STBY: begin
        if (WAKE) begin
          mode_d = wake_act;
        end
      end
      default: begin
        mode_d = MODE_ACT_HI;
      end
    endcase
  end

  // run flags per mode, registered beside the mode itself
  always_comb begin
    run_d = '0;
    case (mode_d)
      MODE_ACT_HI, MODE_ACT_MED: begin
        run_d = '{sys_osc: 1'b1, cpu: 1'b1, periph: 1'b1, pwm: 1'b1,
                  timer_a: 1'b1};
      end
      MODE_SLP_HI, MODE_SLP_MED: begin
        run_d = '{sys_osc: 1'b1, cpu: 1'b0, periph: 1'b1, pwm: 1'b0,
                  timer_a: 1'b1};
      end
      MODE_SUBACT: begin
        run_d = '{sys_osc: 1'b0, cpu: 1'b1, periph: 1'b0, pwm: 1'b0,
                  timer_a: 1'b1};
      end
      MODE_SUBSLP, MODE_WATCH: begin
        run_d = '{sys_osc: 1'b0, cpu: 1'b0, periph: 1'b0, pwm: 1'b0,
                  timer_a: 1'b1};
      end
      MODE_STBY: begin
        run_d = '0;
      end
      default: begin
        run_d = '0;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mode_q <= MODE_ACT_HI;
      run_q <= '{sys_osc: 1'b1, cpu: 1'b1, periph: 1'b1, pwm: 1'b1,
                 timer_a: 1'b1};
    end else if (CE) begin
      mode_q <= mode_d;
      run_q <= run_d;
    end
  end

  // control registers; fixed bits are forced on write and stored, reads return the stored value
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      scr1_q <= SCR1_RST;
      scr2_q <= SCR2_RST;
      tma_q <= TMA_RST;
    end else if (CE) begin
      if (wr_scr1) begin
        scr1_q <= (WDATA & SCR1_WMASK) | SCR1_ONES;
      end
      if (wr_scr2) begin
        scr2_q <= (WDATA & SCR2_WMASK) | SCR2_ONES;
      end
      if (wr_tma) begin
        tma_q <= WDATA[3:0];
      end
    end
  end

  // read mux; unmapped addresses read zero and the counters have no address
  wire [7:0] rd_mux =
    sel_scr1 ? scr1_q :
    sel_scr2 ? scr2_q :
    sel_tma ? {4'h0, tma_q} :
    sel_stat ? {5'h00, mode_q} :
    8'h00;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdata_q <= 8'h00;
    end else if (CE) begin
      rdata_q <= RD ? rd_mux : 8'h00;
    end
  end

  // one tap set for every peripheral; each picks its own bit
  assign SYS_TAPS = sys_cnt;
  assign SUB_TAPS = sub_cnt;
  assign MODE = mode_q;
  assign RUN = run_q;
  assign RDATA = rdata_q;

  // checks on the counters, modes and register port
  sys_zero_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (CE && sys_stop) |=> (sys_cnt == '0))
    else $error("system prescaler not zero in a stop mode");

  // the edge that lifts reset leaves the count at zero, so it starts no attempt
  sys_step_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (RESET_N && CE && is_hi) |=> (sys_cnt == SYS_BITS'($past(sys_cnt) + 1'b1)))
    else $error("system prescaler missed a step at high speed");

  med_hold_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (CE && is_med && !med_tick) |=> (sys_cnt == $past(sys_cnt)))
    else $error("system prescaler stepped between medium ticks");

  med_slow_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (CE && is_med && (ma == 2'h0) && med_tick) ##1 (CE && is_med && (ma == 2'h0))
      [*7] |-> !med_tick)
    else $error("medium divide by eight ticked early");

  psw_clear_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (CE && tma_clr) |=> (sub_cnt == '0))
    else $error("subclock prescaler not cleared by select write");

  psw_step_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (CE && sub_step && !tma_clr) |=> (sub_cnt == SUB_BITS'($past(sub_cnt) + 1'b1)))
    else $error("subclock prescaler missed a step");

  stby_halt_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (mode_q == MODE_STBY) |-> (RUN == '0))
    else $error("something runs in standby");

  subact_run_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (mode_q == MODE_SUBACT) |-> (RUN.cpu && RUN.timer_a && !RUN.periph && !RUN.sys_osc))
    else $error("wrong run set in subactive");

  sleep_pwm_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    ((mode_q == MODE_SLP_HI) || (mode_q == MODE_SLP_MED)) |-> (RUN.periph && !RUN.pwm &&
      !RUN.cpu))
    else $error("wrong run set in sleep");

  sleep_dest_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (CE && runs_code && SLEEP_REQ && row_a) |=> (MODE == MODE_SLP_HI))
    else $error("sleep with all control bits low missed high-speed sleep");

  watch_go_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (CE && runs_code && SLEEP_REQ && row_e) |=> (MODE == MODE_WATCH) ##0 RUN.timer_a)
    else $error("watch entry or time base wrong");

  reg_read_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (CE && RD && sel_scr1) |=> (RDATA == $past(scr1_q)) && ((RDATA & SCR1_ONES) == SCR1_ONES))
    else $error("control register one read back wrong");

  act_run_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    ((mode_q == MODE_ACT_HI) || (mode_q == MODE_ACT_MED)) |-> (RUN == '1))
    else $error("something idle in an active mode");

  watch_run_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    ((mode_q == MODE_WATCH) || (mode_q == MODE_SUBSLP)) |-> (RUN.timer_a && !RUN.cpu &&
      !RUN.sys_osc && !RUN.periph))
    else $error("wrong run set in watch or subsleep");

endmodule

//--- verification/prescaler_and_power_mode_control_bench.sv
// self-checking bench for prescalers, mode control and control registers
`timescale 1ns/1ps
module prescaler_and_power_mode_control_bench
  import pmc_pkg::*;
;
  logic clk, reset_n, ce, wr_s, rd_s, sleep_req, wake;
  logic sub_clk = 1'b0;
  logic [15:0] addr;
  logic [7:0] wdata, rdata;
  logic [SYS_W-1:0] sys_taps;
  logic [SUB_W-1:0] sub_taps;
  pmc_mode_e mode;
  pmc_run_s run;
  logic [2:0] sub_cnt = 3'h0;
  int err_total, total_checks;
  // sleep table, bits are {low, medium, standby, tma b3, direct}
  // the last two rows reach the wake paths that follow the low and medium speed bits
  logic [4:0] row_bits [13] = '{5'h00, 5'h08, 5'h12, 5'h04, 5'h06, 5'h01, 5'h09, 5'h0f,
                                5'h17, 5'h07, 5'h10, 5'h16, 5'h0c};
  pmc_mode_e row_mode [13] = '{MODE_SLP_HI, MODE_SLP_MED, MODE_SUBSLP, MODE_STBY, MODE_WATCH,
    MODE_ACT_HI, MODE_ACT_MED, MODE_ACT_MED, MODE_SUBACT, MODE_ACT_HI, MODE_ACT_HI,
    MODE_WATCH, MODE_STBY};
  pmc_mode_e row_wake [13] = '{MODE_ACT_HI, MODE_ACT_MED, MODE_SUBACT, MODE_ACT_HI, MODE_ACT_HI,
    MODE_ACT_HI, MODE_ACT_MED, MODE_ACT_MED, MODE_SUBACT, MODE_ACT_HI, MODE_ACT_HI,
    MODE_SUBACT, MODE_ACT_MED};
  logic [4:0] row_run [13] = '{5'h15, 5'h15, 5'h01, 5'h00, 5'h01, 5'h1f, 5'h1f, 5'h1f, 5'h09,
                               5'h1f, 5'h1f, 5'h01, 5'h00};

  pmc_top uut (
    .CLK(clk), .RESET_N(reset_n), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
    .RDATA(rdata), .SLEEP_REQ(sleep_req), .WAKE(wake), .SUB_CLK(sub_clk),
    .SYS_TAPS(sys_taps), .SUB_TAPS(sub_taps), .MODE(mode), .RUN(run)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // subclock stand-in, much faster than the real pin so a full wrap fits the run
  always @(posedge clk) begin
    sub_cnt <= sub_cnt + 3'h1;
    if (sub_cnt == 3'h7) begin
      sub_clk <= ~sub_clk;
    end
  end

  task automatic chk(input logic [12:0] seen, input logic [12:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 chk(13'(rdata), 13'(exp), "read data");
  endtask

  // one-cycle event pulse; the new mode is looked at once the edge has landed
  task automatic pulse(input bit is_wake);
    @(posedge clk);
    if (is_wake) wake <= 1'b1;
    else sleep_req <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    sleep_req <= 1'b0;
    #1;
  endtask

  task automatic setbits(input logic [4:0] b, input logic [1:0] div);
    wr(ADDR_SCR1, {b[2], 3'h0, b[4], 1'b1, div});
    wr(ADDR_SCR2, {3'h7, 1'b0, b[0], b[3], 2'h0});
    wr(ADDR_TMA, {4'h0, b[1], 3'h0});
  endtask

  function automatic logic [12:0] tap(input bit sub);
    return sub ? 13'(sub_taps) : sys_taps;
  endfunction

  // cycles between two steps of a prescaler, and the step must be exactly one
  task automatic gap_of(input bit sub, output int gap);
    logic [12:0] v;
    int n;
    v = tap(sub);
    n = 0;
    while (tap(sub) === v && n < 200) begin
      @(posedge clk);
      #1 n++;
    end
    v = tap(sub);
    gap = 0;
    while (tap(sub) === v && gap < 200) begin
      @(posedge clk);
      #1 gap++;
    end
    chk(tap(sub), sub ? 13'(5'(v[4:0] + 5'h1)) : v + 13'h1, "prescaler step");
  endtask

  task automatic t_reset_regs();
    chk(sys_taps, 13'h0, "system prescaler held");
    chk(13'(mode), 13'(MODE_ACT_HI), "mode after reset");
    @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1 chk(sys_taps, 13'h1, "first count");
    rd(ADDR_SCR1, 8'h07);
    rd(ADDR_SCR2, 8'he0);
    rd(ADDR_TMA, 8'h00);
    rd(ADDR_STAT, 8'h00);
    rd(16'h0000, 8'h00);
    wr(ADDR_SCR1, 8'h00);
    rd(ADDR_SCR1, 8'h04);
  endtask

  task automatic t_count();
    logic [12:0] v;
    int g;
    chk(13'(run), 13'h1f, "all running");
    repeat (3) begin
      gap_of(1'b0, g);
      chk(13'(g), 13'h1, "full speed gap");
    end
    // a frozen clock enable must hold the count
    @(posedge clk);
    ce <= 1'b0;
    #1 v = sys_taps;
    repeat (5) @(posedge clk);
    ce <= 1'b1;
    #1 chk(sys_taps, v, "count frozen");
  endtask

  task automatic t_medium();
    int g;
    for (int f = 0; f < 4; f++) begin
      setbits(5'h09, 2'(f));
      pulse(1'b0);
      chk(13'(mode), 13'(MODE_ACT_MED), "medium entered");
      gap_of(1'b0, g);
      gap_of(1'b0, g);
      chk(13'(g), 13'(8 << f), "medium divide");
      setbits(5'h01, 2'h3);
      pulse(1'b0);
    end
  endtask

  task automatic t_modes();
    logic [4:0] s;
    for (int r = 0; r < 13; r++) begin
      setbits(row_bits[r], 2'h3);
      pulse(1'b0);
      chk(13'(mode), 13'(row_mode[r]), "sleep target");
      chk(13'(run), 13'(row_run[r]), "run set");
      rd(ADDR_STAT, {5'h0, row_mode[r]});
      s = sub_taps;
      repeat (70) @(posedge clk);
      #1 chk(13'(sub_taps != s), 13'h1, "subclock prescaler runs");
      if (!run.sys_osc) chk(sys_taps, 13'h0, "stopped prescaler");
      pulse(1'b1);
      chk(13'(mode), 13'(row_wake[r]), "wake target");
      setbits(5'h01, 2'h3);
      pulse(1'b0);
      chk(13'(mode), 13'(MODE_ACT_HI), "back to full speed");
    end
  endtask

  task automatic t_sub();
    int g;
    wr(ADDR_TMA, 8'h0c);
    #1 chk(13'(sub_taps), 13'h0, "tma clear");
    repeat (33) begin
      gap_of(1'b1, g);
      chk(13'(g), 13'h40, "four subclock edges");
    end
    wr(ADDR_TMA, 8'h00);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    err_total = 0;
    total_checks = 0;
    reset_n = 1'b0;
    ce = 1'b1;
    addr = 16'h0;
    wdata = 8'h0;
    wr_s = 1'b0;
    rd_s = 1'b0;
    sleep_req = 1'b0;
    wake = 1'b0;
    repeat (8) @(posedge clk);
    t_reset_regs();
    t_count();
    t_medium();
    t_modes();
    t_sub();
    wrap_up();
  end

  // hang guard, well beyond the roughly six thousand cycles the tests take
  initial begin
    #500us;
    err_total++;
    wrap_up();
  end
endmodule
